//--- src/memsel_pkg.sv
// shared constants, register map and carrier types for the memory select / volume controller
package memsel_pkg;

    // widths and counts
    localparam int ADDR_W    = 5;
    localparam int DATA_W    = 16;
    localparam int MEM_W     = 2;
    localparam int NUM_MEM   = 4;
    localparam int VOL_W     = 8;
    localparam int POS_W     = 8;
    localparam int LEVEL_W   = 4;
    localparam int NUM_TRIM  = 4;
    localparam int TSEL_W    = 2;
    localparam int NUM_PARAM = 19;
    localparam int DB_W      = 16;
    localparam int NUM_SW    = 4;

    // register word addresses
    localparam logic [ADDR_W-1:0] ADDR_CTRL      = 5'h00;
    localparam logic [ADDR_W-1:0] ADDR_VALID     = 5'h01;
    localparam logic [ADDR_W-1:0] ADDR_FIXED_VOL = 5'h02;
    localparam logic [ADDR_W-1:0] ADDR_DEBOUNCE  = 5'h03;
    localparam logic [ADDR_W-1:0] ADDR_STATUS    = 5'h04;
    localparam logic [ADDR_W-1:0] ADDR_TRIM_BASE = 5'h08;

    // memory codes
    localparam logic [MEM_W-1:0] MEM_A = 2'h0;
    localparam logic [MEM_W-1:0] MEM_B = 2'h1;
    localparam logic [MEM_W-1:0] MEM_C = 2'h2;
    localparam logic [MEM_W-1:0] MEM_D = 2'h3;

    // switch vector positions
    localparam int SW_FIRST = 0;
    localparam int SW_SECOND = 1;
    localparam int SW_RAISE = 2;
    localparam int SW_LOWER = 3;

    // rocker use of the gain switches
    localparam logic [1:0] ROCKER_VOLUME = 2'h0;
    localparam logic [1:0] ROCKER_MEMORY = 2'h1;
    localparam logic [1:0] ROCKER_MIXED  = 2'h2;

    // reset values and limits
    localparam logic [NUM_MEM-1:0] VALID_RESET     = 4'h1;
    localparam logic [NUM_MEM-1:0] MASK_NO_D       = 4'h7;
    localparam logic [VOL_W-1:0]   FIXED_VOL_RESET = 8'h80;
    localparam logic [VOL_W-1:0]   DIG_VOL_RESET   = 8'h80;
    localparam logic [VOL_W-1:0]   VOL_MAX         = 8'hff;
    localparam logic [VOL_W-1:0]   VOL_MIN         = 8'h00;
    localparam logic [VOL_W-1:0]   VOL_STEP        = 8'h01;
    localparam logic [DB_W-1:0]    DEBOUNCE_RESET  = 16'h0100;
    localparam logic [DB_W-1:0]    DB_STEP         = 16'h0001;

    typedef enum logic [3:0] {
        MODE_MOM      = 4'b0001,
        MODE_MOM_DED  = 4'b0010,
        MODE_STAT_BIN = 4'b0100,
        MODE_STAT_DED = 4'b1000
    } sel_mode_e;

    typedef struct packed {
        logic [1:0] rocker;
        logic       taper_log;
        logic       vol_digital;
        logic       vol_external;
        logic       second_select_polarity;
        logic       first_select_polarity;
        logic       last_dedicated;
        logic       select_switch_kind;
    } ctrl_s;

    localparam ctrl_s CTRL_RESET = 9'h000;

    typedef struct packed {
        logic       enable;
        logic [TSEL_W-1:0] trimmer;
    } trim_map_s;

    localparam trim_map_s TRIM_MAP_RESET = 3'h0;

    typedef struct packed {
        logic [VOL_W-1:0] volume;
        logic [2:0]       spare;
        logic             second_closed;
        logic             first_closed;
        logic             forced_last;
        logic [MEM_W-1:0] memory;
    } status_s;

endpackage : memsel_pkg

//--- src/memsel_volume_ctrl.sv
// memory select and volume switch controller with trimmer parameter mapping
// How it works
// - four memories; A is always valid and is the fallback
// - switch kind picks momentary pushbutton or static level switch
// - dedicated bit reserves second input for memory D only
// - four modes from kind and dedicated bit; dedicated static mode uses three memories
// - per select input polarity: pull-down reads closed high, pull-up reads closed low
// - single momentary mode starts in A, each press loads next valid memory
// - press in last valid memory wraps to A; only A valid keeps A
// - momentary plus dedicated, second open: cycle valid memories, never D
// - closed second input forces D and first-input presses are ignored
// - opening second input restores the memory held before forcing D
// - binary static mode: open/open A, closed/open B, open/closed C, closed/closed D
// - static modes start where switches point; invalid target falls back to A
// - static selection follows inputs continuously, through interim memories
// - raise input steps gain up one, lower input steps it down one
// - only one of analog or digital volume is active, by configuration
// - volume is a fixed software value or follows the external control
// - rocker may select memories instead of or besides volume steps
// - analog position maps through a log or linear taper
// - four trimmers drive up to 19 parameters of 16 levels each
// - forced D is left only after second input stays open for debounce period
// - dedicated static mode: second closed gives D, else first picks A or B
//
// Our own choices: the placing of the registers and the strobed register port.
`timescale 1ns/1ps
module memsel_volume_ctrl (
    // clock and reset
    input  wire logic                                   clk,
    input  wire logic                                   rstn,
    // register port
    input  wire logic [memsel_pkg::ADDR_W-1:0]          addr,
    input  wire logic [memsel_pkg::DATA_W-1:0]          wdata,
    input  wire logic                                   wr,
    input  wire logic                                   rd,
    output logic      [memsel_pkg::DATA_W-1:0]          rdata,
    // user switches
    input  wire logic                                   first_select_input,
    input  wire logic                                   second_select_input,
    input  wire logic                                   gain_raise_input,
    input  wire logic                                   gain_lower_input,
    // converted potentiometer positions
    input  wire logic [memsel_pkg::POS_W-1:0]           volume_position,
    input  wire logic [memsel_pkg::NUM_TRIM-1:0][memsel_pkg::POS_W-1:0] trimmer_position,
    // results
    output logic      [memsel_pkg::MEM_W-1:0]           memory_sel,
    output logic      [memsel_pkg::VOL_W-1:0]           volume_level,
    output logic      [memsel_pkg::NUM_PARAM-1:0][memsel_pkg::LEVEL_W-1:0] param_level
);
    import memsel_pkg::*;

    ctrl_s                  ctrl_reg;
    logic [NUM_MEM-1:0]     valid_reg;
    logic [VOL_W-1:0]       fixed_vol_reg;
    logic [DB_W-1:0]        debounce_reg;
    logic [NUM_SW-1:0]      sync1_reg;
    logic [NUM_SW-1:0]      sync2_reg;
    logic [NUM_SW-1:0]      closed;
    logic [NUM_SW-1:0]      closed_prev_reg;
    logic [NUM_SW-1:0]      press;
    logic                   second_held_reg;
    logic [DB_W-1:0]        open_cnt_reg;
    logic [MEM_W-1:0]       mem_reg;
    logic [MEM_W-1:0]       saved_reg;
    logic                   forced_reg;
    logic [VOL_W-1:0]       dig_vol_reg;
    logic [VOL_W-1:0]       taper_vol;
    logic [2*POS_W-1:0]     pos_square;
    sel_mode_e              mode;
    logic                   rocker_mem;
    logic                   rocker_vol;
    logic                   step_req;
    logic                   step_up;
    logic [MEM_W-1:0]       bin_sel;
    logic [MEM_W-1:0]       ded_sel;
    logic [NUM_MEM-1:0]     valid_q;
    trim_map_s              trim_map_reg [NUM_PARAM];
    logic [DATA_W-1:0]      read_mux;
    status_s                status;
    logic [ADDR_W-1:0]      trim_idx;

    // search from cur in the given direction for the next valid memory
    function automatic logic [MEM_W-1:0] step_mem(input logic [MEM_W-1:0]   cur,
                                                  input logic [NUM_MEM-1:0] mask,
                                                  input logic               up);
        logic [MEM_W-1:0] idx;
        logic [MEM_W-1:0] res;
        logic             found;
        idx   = cur;
        res   = MEM_A;
        found = 1'b0;
        for (int i = 1; i < NUM_MEM; i++) begin
            idx = up ? idx + MEM_B : idx - MEM_B;
            if (!found && mask[idx]) begin
                res   = idx;
                found = 1'b1;
            end
        end
        return res;
    endfunction : step_mem

    // switch synchronisers and press detection
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            sync1_reg       <= '0;
            sync2_reg       <= '0;
            closed_prev_reg <= '0;
        end else begin
            sync1_reg       <= {gain_lower_input, gain_raise_input,
                                second_select_input, first_select_input};
            sync2_reg       <= sync1_reg;
            closed_prev_reg <= closed;
        end
    end

    always_comb begin
        closed            = sync2_reg;
        closed[SW_FIRST]  = sync2_reg[SW_FIRST] ^ ctrl_reg.first_select_polarity;
        closed[SW_SECOND] = sync2_reg[SW_SECOND] ^ ctrl_reg.second_select_polarity;
        press             = closed & ~closed_prev_reg;
    end

    // mode decode from kind and dedicated setting
    always_comb begin
        if (!ctrl_reg.select_switch_kind) begin
            mode = ctrl_reg.last_dedicated ? MODE_MOM_DED : MODE_MOM;
        end else begin
            mode = ctrl_reg.last_dedicated ? MODE_STAT_DED : MODE_STAT_BIN;
        end
    end

    // dedicated second input: closes at once, opens after debounce period
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            second_held_reg <= 1'b0;
            open_cnt_reg    <= '0;
        end else if (closed[SW_SECOND]) begin
            second_held_reg <= 1'b1;
            open_cnt_reg    <= '0;
        end else if (open_cnt_reg >= debounce_reg) begin
            second_held_reg <= 1'b0;
        end else begin
            open_cnt_reg    <= open_cnt_reg + DB_STEP;
        end
    end

    always_comb begin
        valid_q    = valid_reg | VALID_RESET;
        rocker_mem = ctrl_reg.vol_digital && (ctrl_reg.rocker != ROCKER_VOLUME);
        rocker_vol = ctrl_reg.vol_digital && (ctrl_reg.rocker != ROCKER_MEMORY);
        step_req   = press[SW_FIRST] || (rocker_mem && (press[SW_RAISE] || press[SW_LOWER]));
        step_up    = press[SW_FIRST] || (rocker_mem && press[SW_RAISE]);
        bin_sel    = {closed[SW_SECOND], closed[SW_FIRST]};
        ded_sel    = second_held_reg ? MEM_D : (closed[SW_FIRST] ? MEM_B : MEM_A);
    end

    // memory selection
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            mem_reg    <= MEM_A;
            saved_reg  <= MEM_A;
            forced_reg <= 1'b0;
        end else begin
            unique case (mode)
                MODE_MOM: begin
                    forced_reg <= 1'b0;
                    if (step_req) begin
                        mem_reg <= step_mem(mem_reg, valid_q, step_up);
                    end
                end
                MODE_MOM_DED: begin
                    if (second_held_reg) begin
                        if (!forced_reg) begin
                            saved_reg  <= mem_reg;
                            forced_reg <= 1'b1;
                        end
                        mem_reg <= MEM_D;
                    end else if (forced_reg) begin
                        mem_reg    <= saved_reg;
                        forced_reg <= 1'b0;
                    end else if (mem_reg == MEM_D) begin
                        mem_reg <= MEM_A;
                    end else if (step_req) begin
                        mem_reg <= step_mem(mem_reg, valid_q & MASK_NO_D, step_up);
                    end
                end
                MODE_STAT_BIN: begin
                    forced_reg <= 1'b0;
                    mem_reg    <= valid_q[bin_sel] ? bin_sel : MEM_A;
                end
                MODE_STAT_DED: begin
                    forced_reg <= second_held_reg;
                    mem_reg    <= valid_q[ded_sel] ? ded_sel : MEM_A;
                end
            endcase
        end
    end

    // digital gain stepping
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            dig_vol_reg <= DIG_VOL_RESET;
        end else if (ctrl_reg.vol_external && rocker_vol) begin
            if (press[SW_RAISE] && dig_vol_reg != VOL_MAX) begin
                dig_vol_reg <= dig_vol_reg + VOL_STEP;
            end else if (press[SW_LOWER] && dig_vol_reg != VOL_MIN) begin
                dig_vol_reg <= dig_vol_reg - VOL_STEP;
            end
        end
    end

    always_comb begin
        pos_square = (2*POS_W)'(volume_position) * (2*POS_W)'(volume_position);
        taper_vol  = ctrl_reg.taper_log ? pos_square[2*POS_W-1:POS_W] : volume_position;
    end

    // volume output: one source at a time
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            volume_level <= FIXED_VOL_RESET;
        end else if (!ctrl_reg.vol_external) begin
            volume_level <= fixed_vol_reg;
        end else if (ctrl_reg.vol_digital) begin
            volume_level <= dig_vol_reg;
        end else begin
            volume_level <= taper_vol;
        end
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            memory_sel <= MEM_A;
        end else begin
            memory_sel <= mem_reg;
        end
    end

    assign trim_idx = addr - ADDR_TRIM_BASE;

    // trimmer assignment table and parameter levels
    for (genvar p = 0; p < NUM_PARAM; p++) begin : g_param
        always_ff @(posedge clk or negedge rstn) begin
            if (!rstn) begin
                trim_map_reg[p] <= TRIM_MAP_RESET;
                param_level[p]  <= '0;
            end else begin
                if (wr && addr == ADDR_TRIM_BASE + ADDR_W'(p)) begin
                    trim_map_reg[p] <= wdata[$bits(trim_map_s)-1:0];
                end
                param_level[p] <= trim_map_reg[p].enable ?
                    trimmer_position[trim_map_reg[p].trimmer][POS_W-1:POS_W-LEVEL_W] :
                    '0;
            end
        end
    end

    // software registers
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            ctrl_reg      <= CTRL_RESET;
            valid_reg     <= VALID_RESET;
            fixed_vol_reg <= FIXED_VOL_RESET;
            debounce_reg  <= DEBOUNCE_RESET;
        end else if (wr) begin
            unique case (addr)
                ADDR_CTRL:      ctrl_reg      <= wdata[$bits(ctrl_s)-1:0];
                ADDR_VALID:     valid_reg     <= wdata[NUM_MEM-1:0] | VALID_RESET;
                ADDR_FIXED_VOL: fixed_vol_reg <= wdata[VOL_W-1:0];
                ADDR_DEBOUNCE:  debounce_reg  <= wdata[DB_W-1:0];
                default: ;
            endcase
        end
    end

    always_comb begin
        status.volume        = volume_level;
        status.spare         = '0;
        status.second_closed = closed[SW_SECOND];
        status.first_closed  = closed[SW_FIRST];
        status.forced_last   = forced_reg;
        status.memory        = mem_reg;
        read_mux             = '0;
        if (addr == ADDR_CTRL) begin
            read_mux = DATA_W'(ctrl_reg);
        end else if (addr == ADDR_VALID) begin
            read_mux = DATA_W'(valid_reg);
        end else if (addr == ADDR_FIXED_VOL) begin
            read_mux = DATA_W'(fixed_vol_reg);
        end else if (addr == ADDR_DEBOUNCE) begin
            read_mux = debounce_reg;
        end else if (addr == ADDR_STATUS) begin
            read_mux = status;
        end else if (addr >= ADDR_TRIM_BASE && trim_idx < ADDR_W'(NUM_PARAM)) begin
            read_mux = DATA_W'(trim_map_reg[trim_idx]);
        end
    end

    // read data valid only in the cycle after the strobe
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            rdata <= '0;
        end else begin
            rdata <= rd ? read_mux : '0;
        end
    end

    // checks
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!rstn);

    property p_bin_closed_closed;
        (mode == MODE_STAT_BIN && closed[SW_FIRST] && closed[SW_SECOND] && valid_q[MEM_D])
            |=> (mem_reg == MEM_D);
    endproperty
    a_bin_closed_closed: assert property (p_bin_closed_closed)
        else $error("binary mode did not select D for closed/closed");

    property p_bin_invalid;
        (mode == MODE_STAT_BIN && !closed[SW_FIRST] && closed[SW_SECOND] && !valid_q[MEM_C])
            |=> (mem_reg == MEM_A);
    endproperty
    a_bin_invalid: assert property (p_bin_invalid)
        else $error("invalid static target did not fall back to A");

    property p_ded_static_b;
        (mode == MODE_STAT_DED && !second_held_reg && closed[SW_FIRST] && valid_q[MEM_B])
            |=> (mem_reg == MEM_B);
    endproperty
    a_ded_static_b: assert property (p_ded_static_b)
        else $error("dedicated static mode missed memory B");

    property p_forced_d;
        (mode == MODE_MOM_DED && second_held_reg) |=> (mem_reg == MEM_D && forced_reg);
    endproperty
    a_forced_d: assert property (p_forced_d)
        else $error("closed dedicated input did not force D");

    property p_restore;
        (mode == MODE_MOM_DED && forced_reg && !second_held_reg) |=>
            (mem_reg == $past(saved_reg) && !forced_reg);
    endproperty
    a_restore: assert property (p_restore)
        else $error("memory before forced D not restored");

    property p_never_d;
        (mode == MODE_MOM_DED && !forced_reg && !second_held_reg) |=> (mem_reg != MEM_D);
    endproperty
    a_never_d: assert property (p_never_d)
        else $error("momentary dedicated mode selected D while open");

    property p_wrap_a;
        (mode == MODE_MOM && press[SW_FIRST] && valid_q == VALID_RESET) |=> (mem_reg == MEM_A);
    endproperty
    a_wrap_a: assert property (p_wrap_a)
        else $error("single valid memory did not stay in A");

    property p_step_b;
        (mode == MODE_MOM && press[SW_FIRST] && mem_reg == MEM_A && valid_q[MEM_B])
            |=> (mem_reg == MEM_B);
    endproperty
    a_step_b: assert property (p_step_b)
        else $error("press in A did not load B");

    property p_gain_up;
        (ctrl_reg.vol_external && rocker_vol && press[SW_RAISE] && dig_vol_reg != VOL_MAX)
            |=> (dig_vol_reg == $past(dig_vol_reg) + VOL_STEP);
    endproperty
    a_gain_up: assert property (p_gain_up)
        else $error("raise press did not step gain by one");

    property p_fixed_vol;
        (!ctrl_reg.vol_external) |=> (volume_level == $past(fixed_vol_reg));
    endproperty
    a_fixed_vol: assert property (p_fixed_vol)
        else $error("fixed volume not applied");

    property p_debounce_hold;
        (second_held_reg && !closed[SW_SECOND] && open_cnt_reg < debounce_reg)
            |=> second_held_reg;
    endproperty
    a_debounce_hold: assert property (p_debounce_hold)
        else $error("dedicated input released before debounce period");

    property p_one_step;
        (mode == MODE_MOM && press[SW_FIRST]) |=> !press[SW_FIRST];
    endproperty
    a_one_step: assert property (p_one_step)
        else $error("one closure produced two presses");

endmodule : memsel_volume_ctrl

//--- verification/switch_model.sv
// user switches: turns closed states into pin levels for the chosen wiring
`timescale 1ns/1ps
module switch_model (
    // wanted switch states, high means closed
    input  wire logic [3:0] closed,
    // wiring of the select switches, high means to ground with pull-up
    input  wire logic       pol_first,
    input  wire logic       pol_second,
    // pin levels
    output logic            first_pin,
    output logic            second_pin,
    output logic            raise_pin,
    output logic            lower_pin
);
    assign first_pin  = closed[0] ^ pol_first;
    assign second_pin = closed[1] ^ pol_second;
    // gain switches are wired to the supply, closed reads high
    assign raise_pin  = closed[2];
    assign lower_pin  = closed[3];
endmodule : switch_model

//--- verification/testbench.sv
// self-checking bench for the memory select and volume controller
`timescale 1ns/1ps
module testbench;
    import memsel_pkg::*;
    logic                                   clk = 1'b0;
    logic                                   rstn = 1'b0;
    logic                                   wr = 1'b0;
    logic                                   rd = 1'b0;
    logic [ADDR_W-1:0]                      addr = '0;
    logic [DATA_W-1:0]                      wdata = '0;
    logic [DATA_W-1:0]                      rdata;
    logic [DATA_W-1:0]                      d;
    logic [3:0]                             cl = '0;
    logic                                   p1 = 1'b0;
    logic                                   p2 = 1'b0;
    logic                                   fpin, spin, rpin, lpin;
    logic [POS_W-1:0]                       vpos = '0;
    logic [NUM_TRIM-1:0][POS_W-1:0]         tpos = '0;
    logic [MEM_W-1:0]                       msel;
    logic [VOL_W-1:0]                       vlev;
    logic [NUM_PARAM-1:0][LEVEL_W-1:0]      plev;
    logic [31:0]                            seed = 32'h46;
    int                                     errors = 0;
    int                                     comparisons = 0;
    int                                     m, mask, i;
    int                                     seq[5] = '{0, 1, 3, 2, 0};

    always #4 clk = ~clk;

    switch_model sw (.closed(cl), .pol_first(p1), .pol_second(p2), .first_pin(fpin),
                     .second_pin(spin), .raise_pin(rpin), .lower_pin(lpin));
    memsel_volume_ctrl DUT (.clk(clk), .rstn(rstn), .addr(addr), .wdata(wdata), .wr(wr),
        .rd(rd), .rdata(rdata), .first_select_input(fpin), .second_select_input(spin),
        .gain_raise_input(rpin), .gain_lower_input(lpin), .volume_position(vpos),
        .trimmer_position(tpos), .memory_sel(msel), .volume_level(vlev), .param_level(plev));

    function automatic logic [31:0] xs();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction : xs

    // next valid memory up or down, A is always there to fall back on
    function automatic int step(input int cur, input int msk, input bit up);
        int c;
        for (int k = 1; k <= 4; k++) begin
            c = up ? (cur + k) % 4 : (cur + 4 - k) % 4;
            if (msk[c]) return c;
        end
        return 0;
    endfunction : step

    task automatic results();
        if (errors == 0 && comparisons > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask : results

    task automatic note(input bit bad, input string what);
        comparisons++;
        if (bad) begin
            errors++;
            $display("unexpected at %0t: %s", $time, what);
        end
    endtask : note

    task automatic cmp_reg(input logic [DATA_W-1:0] got, input int e);
        note(got !== DATA_W'(e), $sformatf("register word %h, wanted %h", got, e));
    endtask : cmp_reg
    task automatic cmp_mem(input logic [MEM_W-1:0] got, input int e);
        note(got !== MEM_W'(e), $sformatf("memory %0d, wanted %0d", got, e));
    endtask : cmp_mem
    task automatic cmp_vol(input logic [VOL_W-1:0] got, input int e);
        note(got !== VOL_W'(e), $sformatf("volume %h, wanted %h", got, e));
    endtask : cmp_vol
    task automatic cmp_lvl(input logic [LEVEL_W-1:0] got, input int e);
        note(got !== LEVEL_W'(e), $sformatf("parameter level %h, wanted %h", got, e));
    endtask : cmp_lvl

    task automatic tick(input int n);
        repeat (n) @(posedge clk);
    endtask : tick

    task automatic wreg(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] v);
        @(posedge clk);
        addr  <= a;
        wdata <= v;
        wr    <= 1'b1;
        if (a == ADDR_CTRL) begin
            p1 <= v[2];
            p2 <= v[3];
        end
        @(posedge clk);
        wr <= 1'b0;
    endtask : wreg

    task automatic rreg(input logic [ADDR_W-1:0] a);
        @(posedge clk);
        addr <= a;
        rd   <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
        #1 d = rdata;
    endtask : rreg

    task automatic press(input int w);
        @(posedge clk);
        cl[w] <= 1'b1;
        tick(8);
        cl[w] <= 1'b0;
        tick(8);
    endtask : press

    // static switch states, settled past sync and debounce
    task automatic set_sw(input int s);
        @(posedge clk);
        cl[0] <= s[0];
        cl[1] <= s[1];
        tick(20);
    endtask : set_sw

    initial begin
        repeat (20000) @(posedge clk);
        errors++;
        results();
    end

    initial begin
        tick(4);
        rstn <= 1'b1;
        tick(2);
        cmp_mem(msel, 0);
        cmp_vol(vlev, 8'h80);
        rreg(ADDR_CTRL);
        cmp_reg(d, 0);
        rreg(ADDR_FIXED_VOL);
        cmp_reg(d, 16'h0080);
        rreg(ADDR_DEBOUNCE);
        cmp_reg(d, 16'h0100);
        rreg(5'h1f);
        cmp_reg(d, 0);
        wreg(ADDR_VALID, 16'h0000);
        rreg(ADDR_VALID);
        cmp_reg(d, 1);
        wreg(ADDR_STATUS, 16'hffff);
        rreg(ADDR_STATUS);
        cmp_reg(d, 16'h8000);
        // single momentary: masks A, A-B, A-C, A-D and one random mask walked round back to A
        foreach (seq[j]) begin
            mask = (j < 4) ? (1 << j + 1) - 1 : (xs() & 32'he) | 1;
            wreg(ADDR_VALID, 16'(mask));
            m = 0;
            repeat ($countones(mask[3:0])) begin
                press(SW_FIRST);
                m = step(m, mask, 1);
                cmp_mem(msel, m);
            end
        end
        // momentary with dedicated second input
        wreg(ADDR_VALID, 16'h000f);
        wreg(ADDR_DEBOUNCE, 16'h0004);
        wreg(ADDR_CTRL, 16'h0002);
        press(SW_FIRST);
        cmp_mem(msel, 1);
        set_sw(2);
        cmp_mem(msel, 3);
        press(SW_FIRST);
        cmp_mem(msel, 3);
        @(posedge clk);
        cl[1] <= 1'b0;
        tick(6);
        cmp_mem(msel, 3);
        tick(20);
        cmp_mem(msel, 1);
        m = 1;
        repeat (3) begin
            press(SW_FIRST);
            m = step(m, MASK_NO_D, 1);
            cmp_mem(msel, m);
        end
        // two static inputs, both wirings, then dedicated static
        mask = (xs() & 32'he) | 1;
        wreg(ADDR_VALID, 16'(mask));
        for (int k = 0; k < 3; k++) begin
            wreg(ADDR_CTRL, k == 0 ? 16'h0001 : k == 1 ? 16'h000d : 16'h0003);
            if (k == 2) wreg(ADDR_VALID, 16'h000f);
            foreach (seq[j]) begin
                set_sw(seq[j]);
                m = (k < 2) ? (mask[seq[j]] ? seq[j] : 0) : (seq[j] > 1 ? 3 : seq[j]);
                cmp_mem(msel, m);
            end
        end
        // digital volume steps, then rocker memory stepping
        wreg(ADDR_CTRL, 16'h0030);
        for (i = 0; i < 4; i++) begin
            press(i < 3 ? SW_RAISE : SW_LOWER);
            cmp_vol(vlev, i < 3 ? 8'h81 + i : 8'h82);
        end
        wreg(ADDR_CTRL, 16'h00b0);
        for (i = 0; i < 3; i++) begin
            press(i < 2 ? SW_RAISE : SW_LOWER);
            cmp_mem(msel, i < 2 ? i + 1 : 1);
        end
        // mixed rocker: one raise press steps both memory and gain
        wreg(ADDR_CTRL, 16'h0130);
        press(SW_RAISE);
        cmp_mem(msel, 2);
        cmp_vol(vlev, 8'h83);
        // fixed, linear and log analog volume
        wreg(ADDR_FIXED_VOL, 16'h0042);
        wreg(ADDR_CTRL, 16'h0000);
        tick(4);
        cmp_vol(vlev, 8'h42);
        vpos <= POS_W'(xs());
        wreg(ADDR_CTRL, 16'h0010);
        tick(8);
        cmp_vol(vlev, vpos);
        wreg(ADDR_CTRL, 16'h0050);
        tick(8);
        cmp_vol(vlev, (vpos * vpos) >> 8);
        // one trimmer driving two parameters
        tpos <= xs();
        wreg(ADDR_TRIM_BASE, 16'h0005);
        wreg(ADDR_TRIM_BASE + 5'h12, 16'h0005);
        tick(8);
        cmp_lvl(plev[0], tpos[1][7:4]);
        cmp_lvl(plev[18], tpos[1][7:4]);
        cmp_lvl(plev[5], 0);
        results();
    end
endmodule : testbench
